// ---- verilog/bit_band_pkg.sv ----
`default_nettype none

package bit_band_pkg;

	// ------------------------------------------------------------
	// Address map
	// ------------------------------------------------------------
	localparam logic [31:0] sram_band_base   = 32'h2000_0000;
	localparam logic [31:0] sram_band_last   = 32'h2000_FFFF;
	localparam logic [31:0] sram_alias_base  = 32'h2200_0000;
	localparam logic [31:0] sram_alias_last  = 32'h221F_FFFF;
	localparam logic [31:0] periph_band_base = 32'h4000_0000;
	localparam logic [31:0] periph_alias_base = 32'h4200_0000;
	localparam logic [31:0] periph_alias_last = 32'h43FF_FFFF;
	localparam int          band_bits        = 20;
	localparam int          bit_lsb          = 2;
	localparam int          byte_lsb         = 5;

	// ------------------------------------------------------------
	// Access sizes and carriers
	// ------------------------------------------------------------
	localparam logic [1:0] size_byte = 2'h0;
	localparam logic [1:0] size_half = 2'h1;
	localparam logic [1:0] size_word = 2'h2;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        instr;
		logic [1:0]  size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} req_s;

	typedef struct packed {
		logic        valid;
		logic        error;
		logic [31:0] rdata;
	} rsp_s;

endpackage

`default_nettype wire

// ---- verilog/bit_band_remapper.sv ----
// How it works
// - Lowest 1 MB of peripheral and lowest 64 KB of SRAM is bit-band
// - SRAM alias words map to SRAM band bits
// - Peripheral alias words map to peripheral bits
// - Memory access keeps the original size
// - Direct SRAM band accesses pass unchanged
// - SRAM alias data remapped; fetches not remapped
// - Direct peripheral band accesses pass unchanged
// - Peripheral alias data remapped; fetches refused
// - Alias offset is byte*32 plus bit*4
// - Bit number 0-7 from alias index
// - Written bit 0 sets or clears target
// - Written bits 31:1 are ignored
// - Alias read returns 0 or 1
// - Data lanes stay little-endian
`timescale 1ns/1ps
`default_nettype none

module bit_band_remapper #(
	parameter int band_bits = bit_band_pkg::band_bits
) (
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire bit_band_pkg::req_s cpu_req,
	output logic                   cpu_ready,
	output bit_band_pkg::rsp_s     cpu_rsp,
	output bit_band_pkg::req_s     mem_req,
	input  wire logic              mem_ready,
	input  wire bit_band_pkg::rsp_s mem_rsp
);

	typedef enum {st_idle, st_pass, st_read, st_write} state_e;

	typedef struct packed {
		state_e              state;
		logic                cpu_ready;
		bit_band_pkg::rsp_s  cpu_rsp;
		bit_band_pkg::req_s  mem_req;
		logic                rmw;
		logic [4:0]          shift;
	} regs_s;

	regs_s state_r;
	regs_s state_nxt;

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	// Offset bits above the band width would fall outside the alias span
	if (band_bits < 1 || band_bits > bit_band_pkg::band_bits) begin : g_bad_band
		$error("band_bits must lie between 1 and the full band width");
	end
	// Three bit-number bits must sit between the word and byte fields
	if (bit_band_pkg::byte_lsb - bit_band_pkg::bit_lsb != 3) begin : g_bad_fields
		$error("bit number field must be three bits wide");
	end
	// OR-ing the offset onto a base only works if its low bits are clear
	if (((bit_band_pkg::sram_band_base | bit_band_pkg::periph_band_base)
		& ((32'h1 << band_bits) - 32'h1)) != 32'h0) begin : g_bad_base
		$error("band bases must be aligned to the band size");
	end

	// ------------------------------------------------------------
	// Region decode
	// ------------------------------------------------------------
	logic        in_sram_alias;
	logic        in_periph_alias;
	logic        alias_data;
	logic        fetch_refused;

	always_comb begin
		in_sram_alias   = cpu_req.addr >= bit_band_pkg::sram_alias_base
			&& cpu_req.addr <= bit_band_pkg::sram_alias_last;
		in_periph_alias = cpu_req.addr >= bit_band_pkg::periph_alias_base
			&& cpu_req.addr <= bit_band_pkg::periph_alias_last;
		// Fetches through the SRAM alias go out untouched
		alias_data      = (in_sram_alias || in_periph_alias) && !cpu_req.instr;
		// The peripheral alias never serves code
		fetch_refused   = in_periph_alias && cpu_req.instr;
	end

	// ------------------------------------------------------------
	// Alias address arithmetic
	// ------------------------------------------------------------
	logic [31:0] band_off;
	logic [31:0] band_addr;
	logic [2:0]  bit_num;
	logic [4:0]  lane_shift;

	always_comb begin
		bit_num   = cpu_req.addr[bit_band_pkg::bit_lsb +: 3];
		// Inverse of byte*32 + bit*4 over the 1 MB band
		band_off  = '0;
		band_off[band_bits-1:0] = cpu_req.addr[bit_band_pkg::byte_lsb +: band_bits];
		band_addr = (in_sram_alias ? bit_band_pkg::sram_band_base
			: bit_band_pkg::periph_band_base) | band_off;
		// Bit position inside the little-endian data word
		lane_shift = {band_addr[1:0], bit_num};
	end

	// ------------------------------------------------------------
	// Read-modify-write merge
	// ------------------------------------------------------------
	// Every other bit is written back exactly as it was read
	wire logic [31:0] merged;

	for (genvar i = 0; i < $bits(merged); i++) begin : g_merge
		assign merged[i] = (state_r.shift == 5'(i)) ? state_r.mem_req.wdata[0]
			: state_r.cpu_rsp.rdata[i];
	end

	// ------------------------------------------------------------
	// Alias read result
	// ------------------------------------------------------------
	logic        read_bit;
	logic [31:0] alias_rdata;

	always_comb begin
		read_bit    = mem_rsp.rdata[state_r.shift];
		alias_rdata = {31'h0, read_bit};
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		state_nxt.cpu_rsp.valid = 1'b0;
		case (state_r.state)
			st_idle: begin
				state_nxt.cpu_ready = 1'b0;
				// A held request is not taken again in its own ready cycle
				if (cpu_req.valid && !state_r.cpu_ready) begin
					state_nxt.mem_req = cpu_req;
					state_nxt.rmw     = 1'b0;
					state_nxt.state   = st_pass;
					if (fetch_refused) begin
						// Fetches from peripheral alias get an error, no access
						state_nxt.mem_req.valid   = 1'b0;
						state_nxt.cpu_rsp.valid   = 1'b1;
						state_nxt.cpu_rsp.error   = 1'b1;
						state_nxt.cpu_rsp.rdata   = 32'h0000_0000;
						state_nxt.cpu_ready       = 1'b1;
						state_nxt.state           = st_idle;
					end else if (alias_data) begin
						// Read half first; the write half follows only for writes
						state_nxt.mem_req.addr  = band_addr;
						state_nxt.mem_req.write = 1'b0;
						state_nxt.rmw           = cpu_req.write;
						state_nxt.shift         = lane_shift;
						state_nxt.state         = st_read;
					end
				end
			end
			st_pass: begin
				// Request drops as soon as memory has accepted it
				if (mem_ready) begin
					state_nxt.mem_req.valid = 1'b0;
				end
				if (mem_rsp.valid) begin
					state_nxt.cpu_rsp   = mem_rsp;
					state_nxt.cpu_ready = 1'b1;
					state_nxt.state     = st_idle;
				end
			end
			st_read: begin
				if (mem_ready) begin
					state_nxt.mem_req.valid = 1'b0;
				end
				if (mem_rsp.valid) begin
					// Read word parked here for the merge
					state_nxt.cpu_rsp.rdata = mem_rsp.rdata;
					// A failed read ends the write too, so nothing stale is stored
					if (state_r.rmw && !mem_rsp.error) begin
						state_nxt.state = st_write;
					end else begin
						state_nxt.cpu_rsp.valid = 1'b1;
						state_nxt.cpu_rsp.error = mem_rsp.error;
						state_nxt.cpu_rsp.rdata = alias_rdata;
						state_nxt.cpu_ready = 1'b1;
						state_nxt.state     = st_idle;
					end
				end
			end
			st_write: begin
				// Same size as the alias access; other bits rewritten as read
				if (!state_r.mem_req.write) begin
					state_nxt.mem_req.valid = 1'b1;
					state_nxt.mem_req.write = 1'b1;
					state_nxt.mem_req.wdata = merged;
					state_nxt.state         = st_pass;
				end
			end
			default: begin
				state_nxt.state = st_idle;
			end
		endcase
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	// Reset also drops any half-done read-modify-write
	always_ff @(posedge clock) begin
		if (rst) begin
			// Outputs sit at zero from the first edge of reset
			state_r <= '{state: st_idle, default: '0};
		end else begin
			state_r <= state_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Alias writes ack with the memory write response
	// Response data stays until the next answer, or until the read word of an alias write is parked
	assign cpu_ready = state_r.cpu_ready;
	assign cpu_rsp   = state_r.cpu_rsp;
	assign mem_req   = state_r.mem_req;

endmodule // bit_band_remapper

`default_nettype wire

// ---- verif/bit_band_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module bit_band_chk (
	input wire logic               clock,
	input wire logic               rst,
	input wire bit_band_pkg::req_s cpu_req,
	input wire logic               cpu_ready,
	input wire bit_band_pkg::rsp_s cpu_rsp,
	input wire bit_band_pkg::req_s mem_req
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	wire sa = cpu_req.valid && !cpu_req.instr && cpu_req.addr[31:21] == 11'h110;
	wire pa = cpu_req.valid && cpu_req.addr[31:25] == 7'h21;
	wire mv = mem_req.valid && cpu_req.valid;
	property p_smap; mv && sa |-> mem_req.addr == {12'h200, cpu_req.addr[24:5]}; endproperty
	a_smap: assert property (p_smap) else $error("sram map");
	property p_pmap; mv && pa |-> mem_req.addr == {12'h400, cpu_req.addr[24:5]}; endproperty
	a_pmap: assert property (p_pmap) else $error("periph map");
	property p_size; mv |-> mem_req.size == cpu_req.size; endproperty
	a_size: assert property (p_size) else $error("size");
	property p_pass; mv && !sa && !pa |-> mem_req.addr == cpu_req.addr
		&& mem_req.wdata == cpu_req.wdata; endproperty
	a_pass: assert property (p_pass) else $error("pass");
	property p_bit; mv && (sa || pa) && mem_req.write
		|-> mem_req.wdata[{mem_req.addr[1:0], cpu_req.addr[4:2]}] == cpu_req.wdata[0]; endproperty
	a_bit: assert property (p_bit) else $error("bit");
	property p_read; cpu_ready && (sa || pa) && !cpu_req.write && !cpu_rsp.error
		|-> cpu_rsp.rdata[31:1] == 31'h0; endproperty
	a_read: assert property (p_read) else $error("read");
	property p_fetch; cpu_ready && pa && cpu_req.instr |-> cpu_rsp.error; endproperty
	a_fetch: assert property (p_fetch) else $error("fetch");
	property p_nomem; mem_req.valid |-> mem_req.addr[31:25] != 7'h21; endproperty
	a_nomem: assert property (p_nomem) else $error("alias out");
endmodule // bit_band_chk
bind bit_band_remapper bit_band_chk u_chk (.clock(clock), .rst(rst), .cpu_req(cpu_req),
	.cpu_ready(cpu_ready), .cpu_rsp(cpu_rsp), .mem_req(mem_req));
`default_nettype wire

// ---- verif/bit_band_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
module bit_band_mem (
	input wire logic               clock,
	input wire bit_band_pkg::req_s mem_req,
	output logic                   mem_ready,
	output bit_band_pkg::rsp_s     mem_rsp
);
	logic [31:0] m [logic [29:0]];
	logic [31:0] k, v;
	initial {mem_ready, mem_rsp} = '0;
	// Accepts on alternate cycles so the block must wait
	always @(posedge clock) begin
		v = m.exists(mem_req.addr[31:2]) ? m[mem_req.addr[31:2]] : 32'h0;
		k = mem_req.size[1] ? '1 : mem_req.size[0] ? 32'hFFFF << 16 * mem_req.addr[1]
			: 32'hFF << 8 * mem_req.addr[1:0];
		mem_ready <= !mem_ready;
		mem_rsp <= {2'h0, ~mem_rsp.rdata};
		if (mem_req.valid && mem_ready) begin
			if (mem_req.write) v = v & ~k | mem_req.wdata & k;
			m[mem_req.addr[31:2]] = v;
			mem_rsp <= {2'h2, v};
		end
	end
endmodule // bit_band_mem
`default_nettype wire

// ---- verif/bit_band_remapper_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module bit_band_remapper_bench;
	logic clock = 1'h0, rst = 1'h1, cpu_ready, mem_ready, e;
	logic [31:0] r;
	bit_band_pkg::req_s cpu_req = '0, mem_req;
	bit_band_pkg::rsp_s cpu_rsp, mem_rsp;
	int num_errors = 0, checked = 0, cyc = 0;
	bit_band_remapper DUT (.clock(clock), .rst(rst), .cpu_req(cpu_req), .cpu_ready(cpu_ready),
		.cpu_rsp(cpu_rsp), .mem_req(mem_req), .mem_ready(mem_ready), .mem_rsp(mem_rsp));
	bit_band_mem mem (.clock(clock), .mem_req(mem_req), .mem_ready(mem_ready), .mem_rsp(mem_rsp));
	task end_sim;
		$display("checked %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task chk(string n, logic [31:0] x, g);
		checked++;
		if (g !== x) begin
			num_errors++;
			$display("[FAIL] %s exp %h got %h", n, x, g);
		end
	endtask
	task acc(logic w, i, logic [1:0] s, logic [31:0] a, d);
		@(posedge clock) #1 cpu_req = '{1'h1, w, i, s, a, d};
		do @(posedge clock) #1; while (cpu_ready !== 1'h1);
		r = cpu_rsp.rdata;
		e = cpu_rsp.error;
		@(posedge clock) #1 cpu_req.valid = 1'h0;
	endtask
	task t_sram;
		acc(1, 0, 2, 32'h2000_0004, 32'hA5A5_0F0F);
		acc(0, 0, 2, 32'h2200_0080, 32'h0);
		chk("bit0", 32'h1, r);
		acc(0, 0, 0, 32'h2200_0090, 32'h0);
		chk("bit4", 32'h0, r);
		acc(1, 0, 2, 32'h2200_0080, 32'hFFFF_FFFE);
		acc(1, 0, 2, 32'h2200_00BC, 32'h1);
		acc(0, 0, 2, 32'h2000_0004, 32'h0);
		chk("word", 32'hA5A5_8F0E, r);
		$display("sram alias done");
	endtask
	task t_other;
		acc(1, 0, 0, 32'h4200_000C, 32'h3);
		acc(0, 0, 2, 32'h4000_0000, 32'h0);
		chk("periph", 32'h8, r);
		acc(0, 1, 2, 32'h4200_000C, 32'h0);
		chk("fetch", 32'h1, {31'h0, e});
		acc(0, 1, 2, 32'h2200_00BC, 32'h0);
		chk("sram fetch", 32'h0, r);
		acc(1, 0, 1, 32'h6000_0002, 32'h1234_0000);
		acc(0, 0, 2, 32'h6000_0000, 32'h0);
		chk("pass", 32'h1234_0000, r);
		$display("periph and pass done");
	endtask
	initial forever #50 clock = ~clock;
	always @(posedge clock) if (++cyc > 3000) begin
		num_errors++;
		end_sim;
	end
	initial begin
		repeat (20) @(posedge clock);
		#1 rst = 1'h0;
		t_sram;
		t_other;
		end_sim;
	end
endmodule // bit_band_remapper_bench
`default_nettype wire
